// ===== core/msaf_cfg.svh
`ifndef MSAF_CFG_SVH
`define MSAF_CFG_SVH
// ----------------------------------------
// Register offsets and fields
// ----------------------------------------
`define MSAF_REG_CTRL 8'h40
`define MSAF_PARAM_FIRST 8'h5C
`define MSAF_PARAM_LAST 8'h6E
`define MSAF_ZONE_MAP 8'h5C
`define MSAF_MIN_DUTY 8'h64
`define MSAF_TEMP_LIM 8'h67
`define MSAF_ABS_LIM 8'h6A
`define MSAF_BIT_START 0
`define MSAF_BIT_LOCK 1
`define MSAF_BIT_READY 2
`define MSAF_BIT_OVRID 3
// ----------------------------------------
// Bus addresses
// ----------------------------------------
`define MSAF_ADDR_PREFIX 5'h0B
`define MSAF_ADDR_DEF 7'h2E
`define MSAF_ADDR_SEL0 7'h2C
`define MSAF_ADDR_SEL1 7'h2D
// ----------------------------------------
// Reset values of inactive fan parameters
// ----------------------------------------
`define MSAF_ABS_LIM_RST 8'h64
`define MSAF_TEMP_LIM_RST 8'h5A
`define MSAF_MIN_DUTY_RST 8'h80
`define MSAF_OTHER_RST 8'h00
// ----------------------------------------
// Timing
// ----------------------------------------
`define MSAF_CLK_MHZ 200
`define MSAF_CYC_PER_MS (`MSAF_CLK_MHZ * 1000)
`define MSAF_STUCK_LOW_MS 25
`define MSAF_POWERUP_MS 500
`define MSAF_PWM_DIV 16'h0100
`endif

// ===== core/msaf_pkg.sv
package msaf_pkg;
  typedef enum logic [2:0] {
    MSAF_IDLE = 3'b000,
    MSAF_RX = 3'b001,
    MSAF_ACK = 3'b010,
    MSAF_TX = 3'b011,
    MSAF_TXACK = 3'b100
  } msaf_state_t;
endpackage : msaf_pkg

// ===== core/msaf_top.sv
`include "msaf_cfg.svh"
module msaf_top #(
  parameter int unsigned STUCK_LOW_CYC = `MSAF_STUCK_LOW_MS * `MSAF_CYC_PER_MS,
  parameter int unsigned POWERUP_CYC = `MSAF_POWERUP_MS * `MSAF_CYC_PER_MS
) (
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic serial_clock_pin_in,
  input wire logic serial_data_pin_in,
  output logic serial_data_pin_out,
  output logic serial_data_pin_oe_out,
  input wire logic fan_drive_out_three_in,
  output logic fan_drive_out_three_out,
  output logic fan_drive_out_three_oe_out,
  input wire logic fan_speed_in_four_in,
  input wire logic [7:0] zone1_temp_in,
  input wire logic [7:0] zone2_temp_in,
  input wire logic [7:0] zone3_temp_in,
  output logic fan_drive_one_out,
  output logic fan_drive_two_out,
  output logic fan_speed_four_out,
  output logic fan_ctrl_ready_out
);
  import msaf_pkg::*;
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  localparam int P_SCL = 0;
  localparam int P_SDA = 1;
  localparam int P_EN = 2;
  localparam int P_SEL = 3;
  logic [3:0] s1_r, s2_r, s3_r, pin_q_r, pin_d_r;
  wire logic [3:0] pins = {fan_speed_in_four_in, fan_drive_out_three_in,
                           serial_data_pin_in, serial_clock_pin_in};
  // A change counts only once the second and third stages agree
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      s1_r <= 4'hF;
      s2_r <= 4'hF;
      s3_r <= 4'hF;
      pin_q_r <= 4'hF;
      pin_d_r <= 4'hF;
    end else begin
      s1_r <= pins;
      s2_r <= s1_r;
      s3_r <= s2_r;
      pin_q_r <= (s3_r & ~(s2_r ^ s3_r)) | (pin_q_r & (s2_r ^ s3_r));
      pin_d_r <= pin_q_r;
    end
  end
  wire logic scl_rise = pin_q_r[P_SCL] & ~pin_d_r[P_SCL];
  wire logic scl_fall = ~pin_q_r[P_SCL] & pin_d_r[P_SCL];
  wire logic scl_hi = pin_q_r[P_SCL] & pin_d_r[P_SCL];
  wire logic bus_start = scl_hi & pin_d_r[P_SDA] & ~pin_q_r[P_SDA];
  wire logic bus_stop = scl_hi & ~pin_d_r[P_SDA] & pin_q_r[P_SDA];
  wire logic bus_low = ~pin_q_r[P_SCL] | ~pin_q_r[P_SDA];
  // ----------------------------------------
  // Stuck-low and power-up timers
  // ----------------------------------------
  logic [31:0] low_cnt_r, por_cnt_r;
  logic ready_r;
  wire logic bus_reset = bus_low && (low_cnt_r == STUCK_LOW_CYC - 1);
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      low_cnt_r <= 32'h0000_0000;
      por_cnt_r <= 32'h0000_0000;
      ready_r <= 1'b0;
    end else begin
      low_cnt_r <= !bus_low ? 32'h0000_0000 :
                   (low_cnt_r == STUCK_LOW_CYC) ? low_cnt_r : low_cnt_r + 32'h0000_0001;
      if (por_cnt_r != POWERUP_CYC) por_cnt_r <= por_cnt_r + 32'h0000_0001;
      ready_r <= (por_cnt_r == POWERUP_CYC);
    end
  end
  // ----------------------------------------
  // Address selection
  // ----------------------------------------
  logic addr_lock_r, straps_free_r;
  logic [6:0] addr_r;
  wire logic [6:0] prov_addr = pin_q_r[P_EN] ? `MSAF_ADDR_DEF :
                               pin_q_r[P_SEL] ? `MSAF_ADDR_SEL1 : `MSAF_ADDR_SEL0;
  wire logic [6:0] cur_addr = addr_lock_r ? addr_r : prov_addr;
  // ----------------------------------------
  // Serial target state machine
  // ----------------------------------------
  msaf_state_t state_r;
  logic [3:0] bit_cnt_r;
  logic [1:0] byte_idx_r;
  logic [7:0] shift_r, ptr_r;
  logic rw_r, sda_oe_r;
  logic ctl_start_r, ctl_lock_r, ctl_ovrid_r;
  logic [18:0][7:0] param_r;
  wire logic byte_done = (state_r == MSAF_RX) && scl_fall && (bit_cnt_r == 4'h8);
  wire logic addr_done = byte_done && (byte_idx_r == 2'h0);
  wire logic addr_hit = addr_done && ready_r && (shift_r[7:1] == cur_addr);
  wire logic wr_en = byte_done && (byte_idx_r == 2'h2);
  wire logic in_param = (ptr_r >= `MSAF_PARAM_FIRST) && (ptr_r <= `MSAF_PARAM_LAST);
  wire logic [4:0] pidx = 5'(ptr_r - `MSAF_PARAM_FIRST);
  wire logic [7:0] rd_data = (ptr_r == `MSAF_REG_CTRL) ?
      {4'h0, ctl_ovrid_r, ready_r, ctl_lock_r, ctl_start_r} :
      in_param ? param_r[pidx] : 8'h00;
  always_ff @(posedge clk_sys_in) begin
    if (reset_in || bus_reset) begin
      state_r <= MSAF_IDLE;
      sda_oe_r <= 1'b0;
      bit_cnt_r <= 4'h0;
      byte_idx_r <= 2'h0;
      shift_r <= 8'h00;
      rw_r <= 1'b0;
    end else if (bus_start) begin
      state_r <= MSAF_RX;
      sda_oe_r <= 1'b0;
      bit_cnt_r <= 4'h0;
      byte_idx_r <= 2'h0;
    end else if (bus_stop) begin
      state_r <= MSAF_IDLE;
      sda_oe_r <= 1'b0;
    end else begin
      case (state_r)
        MSAF_RX: begin
          if (scl_rise && bit_cnt_r != 4'h8) begin
            shift_r <= {shift_r[6:0], pin_q_r[P_SDA]};
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end else if (byte_done) begin
            state_r <= (byte_idx_r != 2'h0 || addr_hit) ? MSAF_ACK : MSAF_IDLE;
            sda_oe_r <= (byte_idx_r != 2'h0 || addr_hit);
            if (addr_done) rw_r <= shift_r[0];
          end
        end
        MSAF_ACK: begin
          if (scl_fall) begin
            bit_cnt_r <= rw_r ? 4'h1 : 4'h0;
            shift_r <= rw_r ? rd_data : shift_r;
            sda_oe_r <= rw_r & ~rd_data[7];
            state_r <= rw_r ? MSAF_TX : MSAF_RX;
            if (byte_idx_r != 2'h2) byte_idx_r <= byte_idx_r + 2'h1;
          end
        end
        MSAF_TX: begin
          if (scl_fall) begin
            sda_oe_r <= (bit_cnt_r != 4'h8) & ~shift_r[6];
            shift_r <= {shift_r[6:0], 1'b0};
            bit_cnt_r <= bit_cnt_r + 4'h1;
            if (bit_cnt_r == 4'h8) state_r <= MSAF_TXACK;
          end
        end
        MSAF_TXACK: begin
          if (scl_rise && pin_q_r[P_SDA]) begin
            state_r <= MSAF_IDLE;
          end else if (scl_fall) begin
            shift_r <= rd_data;
            sda_oe_r <= ~rd_data[7];
            bit_cnt_r <= 4'h1;
            state_r <= MSAF_TX;
          end
        end
        default: begin
          state_r <= MSAF_IDLE;
        end
      endcase
    end
  end
  // ----------------------------------------
  // Address latch, pointer, registers
  // ----------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      addr_lock_r <= 1'b0;
      addr_r <= `MSAF_ADDR_DEF;
      straps_free_r <= 1'b0;
      ptr_r <= 8'h00;
      ctl_start_r <= 1'b0;
      ctl_lock_r <= 1'b0;
      ctl_ovrid_r <= 1'b0;
      param_r <= '0;
    end else begin
      if (addr_done && ready_r && !addr_lock_r && shift_r[7:3] == `MSAF_ADDR_PREFIX) begin
        addr_lock_r <= 1'b1;
        addr_r <= prov_addr;
      end
      if (bus_stop && addr_lock_r) straps_free_r <= 1'b1;
      if (byte_done && byte_idx_r == 2'h1) ptr_r <= shift_r;
      if (wr_en && !ctl_lock_r) begin
        if (ptr_r == `MSAF_REG_CTRL) begin
          ctl_start_r <= shift_r[`MSAF_BIT_START];
          ctl_lock_r <= shift_r[`MSAF_BIT_LOCK];
          ctl_ovrid_r <= shift_r[`MSAF_BIT_OVRID];
        end
        if (in_param) param_r[pidx] <= shift_r;
      end
    end
  end
  // ----------------------------------------
  // Fan control
  // ----------------------------------------
  function automatic logic [7:0] def_val(input logic [7:0] a);
    if (a >= `MSAF_ABS_LIM && a < `MSAF_ABS_LIM + 8'h03) return `MSAF_ABS_LIM_RST;
    if (a >= `MSAF_TEMP_LIM && a < `MSAF_TEMP_LIM + 8'h03) return `MSAF_TEMP_LIM_RST;
    if (a >= `MSAF_MIN_DUTY && a < `MSAF_MIN_DUTY + 8'h03) return `MSAF_MIN_DUTY_RST;
    return `MSAF_OTHER_RST;
  endfunction : def_val
  logic [18:0][7:0] eff_p;
  always_comb begin
    for (int i = 0; i < 19; i++) begin
      eff_p[i] = ctl_start_r ? param_r[i] : def_val(`MSAF_PARAM_FIRST + 8'(i));
    end
  end
  // Values go in as an argument so every caller re-evaluates on a write
  function automatic logic [7:0] eff(input logic [18:0][7:0] p, input logic [7:0] a);
    return p[5'(a - `MSAF_PARAM_FIRST)];
  endfunction : eff
  wire logic [2:0][7:0] zt = {zone3_temp_in, zone2_temp_in, zone1_temp_in};
  wire logic over_abs = (zt[0] > eff(eff_p, `MSAF_ABS_LIM)) ||
                        (zt[1] > eff(eff_p, `MSAF_ABS_LIM + 8'h01)) ||
                        (zt[2] > eff(eff_p, `MSAF_ABS_LIM + 8'h02));
  logic [2:0][7:0] duty_nxt, duty_r;
  logic [1:0] zsel;
  logic [7:0] zcfg;
  always_comb begin
    zsel = 2'h0;
    zcfg = 8'h00;
    for (int f = 0; f < 3; f++) begin
      zcfg = eff(eff_p, `MSAF_ZONE_MAP + 8'(f));
      zsel = zcfg[6:5];
      if (over_abs || zsel == 2'h3) duty_nxt[f] = 8'hFF;
      else if (zt[zsel] > eff(eff_p, `MSAF_TEMP_LIM + {6'h00, zsel})) duty_nxt[f] = 8'hFF;
      else duty_nxt[f] = eff(eff_p, `MSAF_MIN_DUTY + 8'(f));
    end
  end
  logic [15:0] div_r;
  logic [7:0] pwm_cnt_r;
  logic [2:0] pwm_r;
  logic pin3_oe_r, fan_speed_in_four_r;
  // Slow PWM rate keeps the fan pins quiet; resolution is the 8-bit duty
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      div_r <= 16'h0000;
      pwm_cnt_r <= 8'h00;
      duty_r <= '0;
      pwm_r <= 3'h0;
      pin3_oe_r <= 1'b0;
      fan_speed_in_four_r <= 1'b0;
    end else begin
      div_r <= (div_r == `MSAF_PWM_DIV - 16'h0001) ? 16'h0000 : div_r + 16'h0001;
      if (div_r == 16'h0000) pwm_cnt_r <= pwm_cnt_r + 8'h01;
      duty_r <= duty_nxt;
      for (int f = 0; f < 3; f++) pwm_r[f] <= (duty_r[f] == 8'hFF) || (pwm_cnt_r < duty_r[f]);
      pin3_oe_r <= straps_free_r & ~pwm_r[2];
      fan_speed_in_four_r <= straps_free_r & pin_q_r[P_SEL];
    end
  end
  assign serial_data_pin_out = 1'b0;
  assign serial_data_pin_oe_out = sda_oe_r;
  assign fan_drive_out_three_out = 1'b0;
  assign fan_drive_out_three_oe_out = pin3_oe_r;
  assign fan_drive_one_out = pwm_r[0];
  assign fan_drive_two_out = pwm_r[1];
  assign fan_speed_four_out = fan_speed_in_four_r;
  assign fan_ctrl_ready_out = ready_r;
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_stuck_release;
    @(posedge clk_sys_in) disable iff (reset_in) bus_reset |=> !sda_oe_r && state_r == MSAF_IDLE;
  endproperty
  a_stuck_release: assert property (p_stuck_release) else $error("bus not released");
  property p_ready_delay;
    @(posedge clk_sys_in) disable iff (reset_in) !ready_r |-> !sda_oe_r;
  endproperty
  a_ready_delay: assert property (p_ready_delay) else $error("answered before ready");
  property p_def_addr;
    @(posedge clk_sys_in) disable iff (reset_in)
      $rose(addr_lock_r) && $past(pin_q_r[P_EN]) |-> addr_r == `MSAF_ADDR_DEF;
  endproperty
  a_def_addr: assert property (p_def_addr) else $error("default address wrong");
  property p_sel_addr;
    @(posedge clk_sys_in) disable iff (reset_in) $rose(addr_lock_r) && !$past(pin_q_r[P_EN])
      |-> addr_r == ($past(pin_q_r[P_SEL]) ? `MSAF_ADDR_SEL1 : `MSAF_ADDR_SEL0);
  endproperty
  a_sel_addr: assert property (p_sel_addr) else $error("selected address wrong");
  property p_pin_input;
    @(posedge clk_sys_in) disable iff (reset_in) !straps_free_r |=> !pin3_oe_r;
  endproperty
  a_pin_input: assert property (p_pin_input) else $error("shared pin driven early");
  property p_addr_once;
    @(posedge clk_sys_in) disable iff (reset_in) addr_lock_r |=> addr_lock_r && $stable(addr_r);
  endproperty
  a_addr_once: assert property (p_addr_once) else $error("address changed");
  property p_abs_full;
    @(posedge clk_sys_in) disable iff (reset_in)
      over_abs |=> duty_r[0] == 8'hFF && duty_r[1] == 8'hFF && duty_r[2] == 8'hFF;
  endproperty
  a_abs_full: assert property (p_abs_full) else $error("not full duty");
  property p_locked;
    @(posedge clk_sys_in) disable iff (reset_in)
      ctl_lock_r && wr_en |=> $stable(param_r) && ctl_lock_r && $stable(ctl_start_r);
  endproperty
  a_locked: assert property (p_locked) else $error("locked write took effect");
endmodule : msaf_top

// ===== test/msaf_host_model.sv
module msaf_host_model (
  input wire logic clk_sys_in,
  input wire logic sda_oe_in,
  input wire logic pin3_oe_in,
  output logic scl_out,
  output logic sda_out,
  output logic pin3_out,
  output logic fan_speed_in_four_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sda_r = 1'b1;
  logic en_drv_r = 1'b1;
  logic en_r = 1'b1;
  logic sel_r = 1'b0;
  logic [2:0] tach_r = 3'h0;
  initial scl_out = 1'b1;
  // ------------------------------
  // Wired lines
  // ------------------------------
  // Pull-ups on data and pin three: nobody drives them high
  assign sda_out = sda_r & ~sda_oe_in;
  assign pin3_out = ~pin3_oe_in & (en_drv_r ? en_r : 1'b1);
  assign fan_speed_in_four_out = en_drv_r ? sel_r : tach_r[2];
  always_ff @(posedge clk_sys_in) begin
    tach_r <= tach_r + 3'h1;
  end
  // ------------------------------
  // Bus phases, about 75 ns a bit
  // ------------------------------
  task automatic ph(input logic c, input logic d, input int n);
    @(posedge clk_sys_in);
    scl_out <= c;
    sda_r <= d;
    repeat (n) @(posedge clk_sys_in);
  endtask : ph
  task automatic straps(input logic drv, input logic en, input logic sel);
    @(posedge clk_sys_in);
    en_drv_r <= drv;
    en_r <= en;
    sel_r <= sel;
  endtask : straps
  task automatic start_c();
    ph(1'b0, 1'b1, 6);
    ph(1'b1, 1'b1, 7);
    ph(1'b1, 1'b0, 7);
    ph(1'b0, 1'b0, 6);
  endtask : start_c
  task automatic stop_c();
    ph(1'b0, 1'b0, 6);
    ph(1'b1, 1'b0, 7);
    ph(1'b1, 1'b1, 13);
  endtask : stop_c
  // Sampled late in the high phase, when the line has settled
  task automatic bit_c(input logic d, output logic s);
    ph(1'b0, d, 6);
    ph(1'b1, d, 7);
    s = sda_out;
  endtask : bit_c
  task automatic byte_c(input logic [7:0] b, output logic [7:0] r);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_c(b[i], s);
      r[i] = s;
    end
  endtask : byte_c
  task automatic xfer(input logic [6:0] a, input logic rd, input logic [7:0] ptr,
                      input logic [7:0] wd, output logic ack, output logic [7:0] rdat);
    logic [7:0] junk;
    logic k;
    rdat = 8'h00;
    start_c();
    byte_c({a, 1'b0}, junk);
    bit_c(1'b1, k);
    ack = ~k;
    if (ack) begin
      byte_c(ptr, junk);
      bit_c(1'b1, k);
      if (rd) begin
        start_c();
        byte_c({a, 1'b1}, junk);
        bit_c(1'b1, k);
        byte_c(8'hFF, rdat);
        bit_c(1'b1, k);
      end else begin
        byte_c(wd, junk);
        bit_c(1'b1, k);
      end
    end
    stop_c();
  endtask : xfer
endmodule : msaf_host_model

// ===== test/msaf_top_tb.sv
module msaf_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PU = 300;
  // Above the longest data-low run of a normal transfer
  localparam int SL = 600;
  logic clk_sys_in, reset_in, ack;
  logic [7:0] z1, z2, z3, rd;
  wire scl, sda, pin3, fan_speed_in_four, sda_o, sda_oe, p3_o, p3_oe, f1, f2, f4, rdy;
  int fail_count, num_checks, cyc;
  msaf_top #(.STUCK_LOW_CYC(SL), .POWERUP_CYC(PU)) msaf_top_inst (
    .clk_sys_in(clk_sys_in), .reset_in(reset_in), .serial_clock_pin_in(scl),
    .serial_data_pin_in(sda), .serial_data_pin_out(sda_o), .serial_data_pin_oe_out(sda_oe),
    .fan_drive_out_three_in(pin3), .fan_drive_out_three_out(p3_o),
    .fan_drive_out_three_oe_out(p3_oe), .fan_speed_in_four_in(fan_speed_in_four), .zone1_temp_in(z1),
    .zone2_temp_in(z2), .zone3_temp_in(z3), .fan_drive_one_out(f1), .fan_drive_two_out(f2),
    .fan_speed_four_out(f4), .fan_ctrl_ready_out(rdy));
  msaf_host_model msaf_host_model_inst (.clk_sys_in(clk_sys_in), .sda_oe_in(sda_oe),
    .pin3_oe_in(p3_oe), .scl_out(scl), .sda_out(sda), .pin3_out(pin3), .fan_speed_in_four_out(fan_speed_in_four));
  initial begin
    clk_sys_in = 1'b0;
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end
  // Hang guard, well above the expected run
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fail_count++;
      results();
    end
  end
  task automatic chk(input bit ok, input string m);
    num_checks++;
    if (!ok) begin
      fail_count++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask : chk
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    msaf_host_model_inst.xfer(7'h2E, 1'b0, p, d, ack, rd);
    chk(ack === 1'b1, "write not acked");
  endtask : wr
  task automatic rdchk(input logic [7:0] p, input logic [7:0] e);
    msaf_host_model_inst.xfer(7'h2E, 1'b1, p, 8'h00, ack, rd);
    chk(ack === 1'b1 && rd === e, "read value");
  endtask : rdchk
  // Majority over a short window: 00h duty stays low, full duty stays high
  task automatic duty(input bit sel, input bit full);
    int n;
    n = 0;
    repeat (10) @(posedge clk_sys_in);
    repeat (600) begin
      @(posedge clk_sys_in);
      n += ((sel ? f2 : f1) === 1'b1);
    end
    chk((n > 300) == full, "duty level");
  endtask : duty
  task automatic t_power();
    repeat (2) @(posedge clk_sys_in);
    chk(rdy === 1'b0 && p3_oe === 1'b0, "early ready or pin drive");
    chk(sda_o === 1'b0 && p3_o === 1'b0, "open drain level not low");
    repeat (PU - 6) @(posedge clk_sys_in);
    chk(rdy === 1'b0, "ready too soon");
    repeat (12) @(posedge clk_sys_in);
    chk(rdy === 1'b1, "ready late");
  endtask : t_power
  task automatic t_addr(input logic e, input logic s, input logic [6:0] a, input logic [6:0] alt);
    logic v;
    int n;
    msaf_host_model_inst.straps(1'b1, e, s);
    @(posedge clk_sys_in);
    reset_in <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    msaf_host_model_inst.xfer(a, 1'b0, 8'h40, 8'h00, ack, rd);
    chk(ack === 1'b0 && rdy === 1'b0, "answered before ready");
    repeat (PU + 12) @(posedge clk_sys_in);
    msaf_host_model_inst.xfer(7'h50, 1'b1, 8'h40, 8'h00, ack, rd);
    chk(ack === 1'b0, "foreign address acked");
    chk(p3_oe === 1'b0 && f4 === 1'b0, "shared pins left early");
    msaf_host_model_inst.xfer(a, 1'b1, 8'h40, 8'h00, ack, rd);
    chk(ack === 1'b1 && rd === 8'h04, "own address or ctrl value");
    msaf_host_model_inst.straps(1'b0, 1'b0, 1'b0);
    v = f4;
    n = 0;
    repeat (40) begin
      @(posedge clk_sys_in);
      n += (f4 !== v);
      v = f4;
    end
    chk(n > 2, "tach not passed through");
    msaf_host_model_inst.xfer(alt, 1'b0, 8'h40, 8'h00, ack, rd);
    chk(ack === 1'b0, "address not latched");
  endtask : t_addr
  task automatic t_fan();
    @(posedge clk_sys_in);
    z1 <= 8'h70;
    duty(1'b0, 1'b1);
    for (int p = 'h67; p <= 'h6C; p++) wr(p[7:0], 8'hFF);
    duty(1'b0, 1'b1);
    wr(8'h40, 8'h01);
    duty(1'b0, 1'b0);
    for (int p = 'h67; p <= 'h69; p++) wr(p[7:0], 8'h60);
    wr(8'h5D, 8'h20);
    z1 <= 8'h50;
    z2 <= 8'h70;
    duty(1'b1, 1'b1);
    duty(1'b0, 1'b0);
    chk(p3_oe === 1'b1, "pin three not pulled low");
    wr(8'h6C, 8'hF0);
    z3 <= 8'hF5;
    duty(1'b0, 1'b1);
    chk(p3_oe === 1'b0, "pin three not at full duty");
    wr(8'h40, 8'h03);
    wr(8'h40, 8'h00);
    wr(8'h64, 8'hFF);
    rdchk(8'h40, 8'h07);
    rdchk(8'h64, 8'h00);
    rdchk(8'h6A, 8'hFF);
    rdchk(8'h20, 8'h00);
  endtask : t_fan
  task automatic t_stuck();
    msaf_host_model_inst.start_c();
    msaf_host_model_inst.byte_c(8'h5C, rd);
    msaf_host_model_inst.ph(1'b0, 1'b1, 8);
    chk(sda_oe === 1'b1, "no ack driven");
    msaf_host_model_inst.ph(1'b0, 1'b1, SL + 20);
    chk(sda_oe === 1'b0, "data not released");
    msaf_host_model_inst.stop_c();
    rdchk(8'h40, 8'h07);
  endtask : t_stuck
  initial begin
    reset_in = 1'b1;
    z1 = 8'h00;
    z2 = 8'h00;
    z3 = 8'h00;
    fail_count = 0;
    num_checks = 0;
    cyc = 0;
    repeat (3) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    t_power();
    t_addr(1'b0, 1'b0, 7'h2C, 7'h2D);
    t_addr(1'b0, 1'b1, 7'h2D, 7'h2E);
    t_addr(1'b1, 1'b0, 7'h2E, 7'h2C);
    t_fan();
    t_stuck();
    results();
  end
endmodule : msaf_top_tb
